// ---- io_image_pkg.sv ----
// constants for the process-image block: areas, unit kinds, timing
// Notes on behaviour
// (R1) image is 20 words, bit addressable
// (R2) words assigned by mounting position, left first
// (R3) each unit takes whole 16-bit words
// (R4) unassigned image words never reach terminals
// (R5) every image bit can be forced
// (R6) image clears on mode change, power, tool
// (R7) fatal halt clears, user alarm halt retains
// (R8) inputs sampled once per scan, after program
// (R9) immediate refresh reads and writes word range
// (R10) input filter 0 to 32 ms, default 8
// (R11) zero filter keeps 20 us/300 us delays
// (R12) outputs sent once per scan, after program
// (R13) immediate refresh sends range outputs at once
// (R14) last write to an output bit wins
// (R15) program never writes input bits
// (R16) bus-unit area 400 words, 1500 to 1899
// (R17) unit n starts at 1500 plus 25n
// (R18) bus words exchanged per scan, never immediately
// (R19) bus area is work storage, forceable
// (R20) bus area clears like image, alarm retains
// (R21) forced bits hold through refresh and writes
package io_image_pkg;
   localparam int WORD_BITS = 16;
   localparam int IMG_BASE = 0;
   localparam int IMG_WORDS = 20;
   localparam int BUS_BASE = 1500;
   localparam int BUS_UNITS = 16;
   localparam int BUS_PER_UNIT = 25;
   localparam int BUS_WORDS = 400;
   localparam int ADDR_W = 11;
   localparam int POINTS_W = 7;
   localparam int FILT_W = 6;
   localparam logic [5:0] FILTER_DEFAULT_MS = 6'h08;
   localparam logic [5:0] FILTER_MAX_MS = 6'h20;
   localparam logic [1:0] KIND_NONE = 2'h0;
   localparam logic [1:0] KIND_IN = 2'h1;
   localparam logic [1:0] KIND_OUT = 2'h2;
   localparam logic [1:0] FORCE_SET = 2'h0;
   localparam logic [1:0] FORCE_RESET = 2'h1;
   localparam logic [1:0] FORCE_RELEASE = 2'h2;
   localparam logic [1:0] FORCE_RELEASE_ALL = 2'h3;
   localparam int CLK_MHZ = 50;
   localparam int ON_DELAY_US = 20;
   localparam int OFF_DELAY_US = 300;
   // longest on and off delays both taken as printed, in whole clock cycles
   localparam int ON_DELAY_CYC = ON_DELAY_US * CLK_MHZ;
   localparam int OFF_DELAY_CYC = OFF_DELAY_US * CLK_MHZ;
   localparam int CYC_PER_MS = 1000 * CLK_MHZ;
   localparam int FILT_CNT_W = 21;
   localparam int FIFO_DEPTH = 16;
endpackage

// ---- io_bus_fifo.sv ----
// word fifo between the bus-area walker and the bus units
`timescale 1ns/1ps
module io_bus_fifo #(
   parameter int WIDTH = 25,
   parameter int DEPTH = io_image_pkg::FIFO_DEPTH
)(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0] wp;
      logic [PW-1:0] rp;
      logic [PW:0] cnt;
   } fifo_t;
   fifo_t r;
   fifo_t n;
   logic push;
   logic pop;

   assign in_ready = (r.cnt != (PW+1)'(DEPTH));
   assign out_valid = (r.cnt != '0);
   assign out_data = r.mem[r.rp];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      n = r;
      if (push) begin
         n.mem[r.wp] = in_data;
         n.wp = (r.wp == PW'(DEPTH - 1)) ? '0 : r.wp + 1'b1;
      end
      if (pop) begin
         n.rp = (r.rp == PW'(DEPTH - 1)) ? '0 : r.rp + 1'b1;
      end
      n.cnt = r.cnt + (PW+1)'(push) - (PW+1)'(pop);
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end
endmodule

// ---- io_input_filter.sv ----
// one input point: two-stage synchroniser and response-time filter
`timescale 1ns/1ps
module io_input_filter #(
   parameter int CNT_W = io_image_pkg::FILT_CNT_W,
   parameter int CYC_PER_MS = io_image_pkg::CYC_PER_MS,
   parameter int ON_CYC = io_image_pkg::ON_DELAY_CYC,
   parameter int OFF_CYC = io_image_pkg::OFF_DELAY_CYC
)(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // raw point and setting
   input wire logic pin,
   input wire logic [5:0] ms,
   // filtered level
   output logic level
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic lvl;
      logic [CNT_W-1:0] cnt;
   } filt_t;
   filt_t r;
   filt_t n;
   logic [5:0] ms_c;
   logic [CNT_W-1:0] lim;

   assign level = r.lvl;

   always_comb begin
      n = r;
      n.s1 = pin;
      n.s2 = r.s1;
      // (R10) clamp to 32 ms
      ms_c = (ms > io_image_pkg::FILTER_MAX_MS) ? io_image_pkg::FILTER_MAX_MS : ms;
      // (R11) residual element delay
      if (ms_c == '0) begin
         lim = r.lvl ? CNT_W'(OFF_CYC) : CNT_W'(ON_CYC);
      end else begin
         lim = CNT_W'(int'(ms_c) * CYC_PER_MS);
      end
      // a change must hold for the whole time, so chatter restarts it
      if (r.s2 == r.lvl) begin
         n.cnt = '0;
      end else if (r.cnt + 1'b1 >= lim) begin
         n.lvl = r.s2;
         n.cnt = '0;
      end else begin
         n.cnt = r.cnt + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end
endmodule

// ---- io_image_refresh.sv ----
// process image of basic i/o and bus units, with scan and immediate refresh
`timescale 1ns/1ps
module io_image_refresh #(
   parameter int CYC_PER_MS = io_image_pkg::CYC_PER_MS,
   parameter int OFF_DELAY_CYC = io_image_pkg::OFF_DELAY_CYC,
   parameter int FIFO_DEPTH = io_image_pkg::FIFO_DEPTH
)(
   // clock and reset
   input wire logic CLK,
   input wire logic RST_B,
   // operating state
   input wire logic MODE_RUN,
   input wire logic FATAL_HALT,
   input wire logic FATAL_USER,
   // mounting and input settings, one field per position
   input wire logic [39:0] UNIT_KIND,
   input wire logic [139:0] UNIT_POINTS,
   input wire logic [119:0] UNIT_FILTER_MS,
   // terminals of the basic units
   input wire logic [319:0] IN_PINS,
   output logic [319:0] OUT_PINS,
   // program access
   input wire logic PRG_WE,
   input wire logic [10:0] PRG_ADDR,
   input wire logic [15:0] PRG_WDATA,
   input wire logic [15:0] PRG_BMASK,
   output logic [15:0] PRG_RDATA,
   // scan and immediate refresh
   input wire logic SCAN_END,
   output logic SCAN_DONE,
   output logic REFRESH_BUSY,
   input wire logic IMM_REQ,
   input wire logic [10:0] IMM_FIRST,
   input wire logic [10:0] IMM_LAST,
   output logic IMM_DONE,
   // programming tool
   input wire logic TOOL_FORCE_REQ,
   input wire logic [1:0] TOOL_FORCE_OP,
   input wire logic [10:0] TOOL_ADDR,
   input wire logic [3:0] TOOL_BIT,
   input wire logic TOOL_CLEAR,
   // bus units
   input wire logic [15:0] BUS_PRESENT,
   input wire logic BUS_IN_VALID,
   output logic BUS_IN_READY,
   input wire logic [15:0] BUS_IN_DATA,
   output logic BUS_OUT_VALID,
   input wire logic BUS_OUT_READY,
   output logic [8:0] BUS_OUT_ADDR,
   output logic [15:0] BUS_OUT_DATA
);
   localparam int IW = io_image_pkg::IMG_WORDS;
   localparam int BW = io_image_pkg::BUS_WORDS;
   localparam int BPU = io_image_pkg::BUS_PER_UNIT;
   localparam int WB = io_image_pkg::WORD_BITS;

   typedef enum logic [1:0] {
      W_IDLE = 2'h0,
      W_BUS = 2'h1,
      W_DONE = 2'h3
   } walk_t;

   typedef struct packed {
      logic [IW-1:0][15:0] img;
      logic [IW-1:0][15:0] ifs;
      logic [IW-1:0][15:0] ifr;
      logic [BW-1:0][15:0] bus;
      logic [BW-1:0][15:0] bfs;
      logic [BW-1:0][15:0] bfr;
      logic [IW-1:0][15:0] outp;
      logic [15:0] rdata;
      logic mode_prev;
      walk_t st;
      logic [3:0] unit;
      logic [4:0] word;
      logic imm_done;
      logic scan_done;
   } state_t;

   state_t r;
   state_t n;
   logic [IW-1:0][1:0] kind;
   logic [IW-1:0][5:0] filt;
   logic [IW-1:0][15:0] in_lvl;
   logic [8:0] bidx;
   logic fifo_ready;
   logic push;
   logic [15:0] mask;
   logic [15:0] tbit;
   logic clr;

   function automatic logic [15:0] frc(input logic [15:0] v, input logic [15:0] fs, input logic [15:0] fr);
      return (v & ~fr) | fs;
   endfunction

   // (R1) twenty image words
   function automatic logic in_img(input logic [10:0] a);
      return int'(a) >= io_image_pkg::IMG_BASE && int'(a) < io_image_pkg::IMG_BASE + IW;
   endfunction

   // (R16) 400-word bus area
   function automatic logic in_bus(input logic [10:0] a);
      return int'(a) >= io_image_pkg::BUS_BASE && int'(a) < io_image_pkg::BUS_BASE + BW;
   endfunction

   // (R2) words handed out left to right
   always_comb begin
      int base;
      int nw;
      base = 0;
      nw = 0;
      kind = '0;
      filt = '0;
      for (int u = 0; u < IW; u++) begin
         // (R3) whole words, rounded up
         nw = (int'(UNIT_POINTS[u*io_image_pkg::POINTS_W +: io_image_pkg::POINTS_W]) + WB - 1) / WB;
         for (int w = 0; w < IW; w++) begin
            if (w >= base && w < base + nw) begin
               kind[w] = UNIT_KIND[u*2 +: 2];
               filt[w] = UNIT_FILTER_MS[u*io_image_pkg::FILT_W +: io_image_pkg::FILT_W];
            end
         end
         base = base + nw;
      end
   end

   // (R10) one filter per input point
   genvar gw;
   genvar gb;
   generate
      for (gw = 0; gw < IW; gw++) begin : g_word
         for (gb = 0; gb < WB; gb++) begin : g_bit
            io_input_filter #(
               .CNT_W(io_image_pkg::FILT_CNT_W),
               .CYC_PER_MS(CYC_PER_MS),
               .ON_CYC(io_image_pkg::ON_DELAY_CYC),
               .OFF_CYC(OFF_DELAY_CYC)
            ) u_filt (
               .clk(CLK),
               .rst_b(RST_B),
               .pin(IN_PINS[gw*WB + gb]),
               .ms(filt[gw]),
               .level(in_lvl[gw][gb])
            );
         end
      end
   endgenerate

   // (R17) unit n at base plus 25n
   assign bidx = 9'(int'(r.unit) * BPU + int'(r.word));

   // walker takes a word only when the fifo can take the old one
   assign BUS_IN_READY = (r.st == W_BUS) && BUS_PRESENT[r.unit] && fifo_ready;
   assign push = BUS_IN_READY && BUS_IN_VALID;
   assign mask = PRG_BMASK;
   assign tbit = 16'h0001 << TOOL_BIT;
   // (R6) mode change, tool clear
   // (R7) user alarm halt keeps the image
   assign clr = (MODE_RUN != r.mode_prev) || TOOL_CLEAR || (FATAL_HALT && !FATAL_USER);

   io_bus_fifo #(
      .WIDTH(25),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(CLK),
      .rst_b(RST_B),
      .in_valid(push),
      .in_ready(fifo_ready),
      .in_data({bidx, r.bus[bidx]}),
      .out_valid(BUS_OUT_VALID),
      .out_ready(BUS_OUT_READY),
      .out_data({BUS_OUT_ADDR, BUS_OUT_DATA})
   );

   always_comb begin
      int ia;
      int ba;
      ia = 0;
      ba = 0;
      n = r;
      n.imm_done = 1'b0;
      n.scan_done = 1'b0;
      n.mode_prev = MODE_RUN;

      // program read, one cycle later
      n.rdata = 16'h0000;
      if (in_img(PRG_ADDR)) begin
         n.rdata = r.img[int'(PRG_ADDR) - io_image_pkg::IMG_BASE];
      end else if (in_bus(PRG_ADDR)) begin
         n.rdata = r.bus[int'(PRG_ADDR) - io_image_pkg::BUS_BASE];
      end

      // (R14) later writes simply overwrite
      if (PRG_WE) begin
         if (in_img(PRG_ADDR)) begin
            ia = int'(PRG_ADDR) - io_image_pkg::IMG_BASE;
            // (R15) input words ignore writes
            if (kind[ia] != io_image_pkg::KIND_IN) begin
               // (R21) forced bits survive writes
               n.img[ia] = frc((r.img[ia] & ~mask) | (PRG_WDATA & mask), r.ifs[ia], r.ifr[ia]);
            end
         end else if (in_bus(PRG_ADDR)) begin
            ba = int'(PRG_ADDR) - io_image_pkg::BUS_BASE;
            // (R19) free words are work storage
            n.bus[ba] = frc((r.bus[ba] & ~mask) | (PRG_WDATA & mask), r.bfs[ba], r.bfr[ba]);
         end
      end

      // (R5) force and release, image
      if (TOOL_FORCE_REQ && in_img(TOOL_ADDR)) begin
         ia = int'(TOOL_ADDR) - io_image_pkg::IMG_BASE;
         unique case (TOOL_FORCE_OP)
            io_image_pkg::FORCE_SET: begin
               n.ifs[ia] = r.ifs[ia] | tbit;
               n.ifr[ia] = r.ifr[ia] & ~tbit;
               n.img[ia] = n.img[ia] | tbit;
            end
            io_image_pkg::FORCE_RESET: begin
               n.ifr[ia] = r.ifr[ia] | tbit;
               n.ifs[ia] = r.ifs[ia] & ~tbit;
               n.img[ia] = n.img[ia] & ~tbit;
            end
            io_image_pkg::FORCE_RELEASE: begin
               n.ifs[ia] = r.ifs[ia] & ~tbit;
               n.ifr[ia] = r.ifr[ia] & ~tbit;
            end
            io_image_pkg::FORCE_RELEASE_ALL: begin
               n.ifs = '0;
               n.ifr = '0;
               n.bfs = '0;
               n.bfr = '0;
            end
         endcase
      end

      // (R19) force and release, bus area
      if (TOOL_FORCE_REQ && in_bus(TOOL_ADDR)) begin
         ba = int'(TOOL_ADDR) - io_image_pkg::BUS_BASE;
         unique case (TOOL_FORCE_OP)
            io_image_pkg::FORCE_SET: begin
               n.bfs[ba] = r.bfs[ba] | tbit;
               n.bfr[ba] = r.bfr[ba] & ~tbit;
               n.bus[ba] = n.bus[ba] | tbit;
            end
            io_image_pkg::FORCE_RESET: begin
               n.bfr[ba] = r.bfr[ba] | tbit;
               n.bfs[ba] = r.bfs[ba] & ~tbit;
               n.bus[ba] = n.bus[ba] & ~tbit;
            end
            io_image_pkg::FORCE_RELEASE: begin
               n.bfs[ba] = r.bfs[ba] & ~tbit;
               n.bfr[ba] = r.bfr[ba] & ~tbit;
            end
            io_image_pkg::FORCE_RELEASE_ALL: begin
               n.ifs = '0;
               n.ifr = '0;
               n.bfs = '0;
               n.bfr = '0;
            end
         endcase
      end

      // (R9) immediate refresh of a word range
      if (IMM_REQ) begin
         for (int w = 0; w < IW; w++) begin
            if (w + io_image_pkg::IMG_BASE >= int'(IMM_FIRST) && w + io_image_pkg::IMG_BASE <= int'(IMM_LAST)) begin
               if (kind[w] == io_image_pkg::KIND_IN) begin
                  n.img[w] = frc(in_lvl[w], n.ifs[w], n.ifr[w]);
               end
               // (R13) outputs of the range sent now
               if (kind[w] == io_image_pkg::KIND_OUT) begin
                  n.outp[w] = n.img[w];
               end
            end
         end
         n.imm_done = 1'b1;
      end

      unique case (r.st)
         W_IDLE: begin
            // (R8) inputs taken at scan end, otherwise only by an immediate refresh
            // (R12) outputs sent at scan end, otherwise only by an immediate refresh
            if (SCAN_END) begin
               for (int w = 0; w < IW; w++) begin
                  if (kind[w] == io_image_pkg::KIND_IN) begin
                     n.img[w] = frc(in_lvl[w], n.ifs[w], n.ifr[w]);
                  end
                  // (R4) unassigned words never leave
                  if (kind[w] == io_image_pkg::KIND_OUT) begin
                     n.outp[w] = n.img[w];
                  end
               end
               n.st = W_BUS;
               n.unit = '0;
               n.word = '0;
            end
         end
         W_BUS: begin
            // (R18) bus words only in the scan walk
            if (!BUS_PRESENT[r.unit] || push) begin
               if (push) begin
                  n.bus[bidx] = frc(BUS_IN_DATA, r.bfs[bidx], r.bfr[bidx]);
               end
               if (!BUS_PRESENT[r.unit] || r.word == 5'(BPU - 1)) begin
                  n.word = '0;
                  n.unit = r.unit + 1'b1;
                  if (r.unit == 4'(io_image_pkg::BUS_UNITS - 1)) begin
                     n.st = W_DONE;
                  end
               end else begin
                  n.word = r.word + 1'b1;
               end
            end
         end
         W_DONE: begin
            n.scan_done = 1'b1;
            n.st = W_IDLE;
         end
         default: begin
            n.st = W_IDLE;
         end
      endcase

      // clear has last say; forced bits keep their value
      // (R20) bus area cleared alike
      if (clr) begin
         n.img = n.ifs;
         n.bus = n.bfs;
      end
   end

   assign REFRESH_BUSY = (r.st != W_IDLE);
   assign SCAN_DONE = r.scan_done;
   assign IMM_DONE = r.imm_done;
   assign PRG_RDATA = r.rdata;
   assign OUT_PINS = r.outp;

   // (R6) power-up leaves everything zero
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end
endmodule

// ---- io_image_refresh_properties.sv ----
// port checks for the process-image block
`timescale 1ns/1ps
module io_image_refresh_properties (
   // clock and reset
   input wire logic CLK,
   input wire logic RST_B,
   // refresh control
   input wire logic SCAN_END,
   input wire logic SCAN_DONE,
   input wire logic REFRESH_BUSY,
   input wire logic IMM_REQ,
   input wire logic IMM_DONE,
   // program and terminals
   input wire logic [10:0] PRG_ADDR,
   input wire logic [15:0] PRG_RDATA,
   input wire logic [319:0] OUT_PINS,
   // bus units
   input wire logic BUS_IN_READY,
   input wire logic BUS_OUT_VALID,
   input wire logic BUS_OUT_READY,
   input wire logic [8:0] BUS_OUT_ADDR,
   input wire logic [15:0] BUS_OUT_DATA
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_B);
   imm_answer_a: assert property (IMM_REQ |=> IMM_DONE)
      else $error("immediate done missing");
   imm_cause_a: assert property (IMM_DONE |-> $past(IMM_REQ))
      else $error("immediate done without request");
   scan_start_a: assert property (SCAN_END && !REFRESH_BUSY |=> REFRESH_BUSY)
      else $error("scan refresh not started");
   scan_floor_a: assert property ($rose(REFRESH_BUSY) |-> !SCAN_DONE [*8])
      else $error("bus walk ended too soon");
   scan_end_a: assert property (SCAN_DONE |-> !REFRESH_BUSY)
      else $error("busy after scan done");
   out_moment_a: assert property (!$stable(OUT_PINS) |-> $past(IMM_REQ) || ($past(SCAN_END) && !$past(REFRESH_BUSY)))
      else $error("outputs changed outside refresh");
   bus_stand_a: assert property (BUS_OUT_VALID && !BUS_OUT_READY |=>
      BUS_OUT_VALID && $stable(BUS_OUT_DATA) && $stable(BUS_OUT_ADDR))
      else $error("bus word dropped before taken");
   bus_index_a: assert property (BUS_OUT_VALID |-> BUS_OUT_ADDR < 9'd400)
      else $error("bus index out of area");
   bus_idle_a: assert property (!REFRESH_BUSY |-> !BUS_IN_READY)
      else $error("bus word taken outside scan");
   unmapped_zero_a: assert property ((PRG_ADDR >= 11'd20 && PRG_ADDR < 11'd1500) || PRG_ADDR > 11'd1899
      |=> PRG_RDATA == 16'h0)
      else $error("unmapped read not zero");
   scan_c: cover property (SCAN_DONE);
   imm_c: cover property (IMM_DONE);
   take_c: cover property (BUS_OUT_VALID && BUS_OUT_READY);
   full_c: cover property (REFRESH_BUSY && !BUS_IN_READY);
endmodule
bind io_image_refresh io_image_refresh_properties io_image_refresh_properties_inst (.CLK(CLK), .RST_B(RST_B),
   .SCAN_END(SCAN_END), .SCAN_DONE(SCAN_DONE), .REFRESH_BUSY(REFRESH_BUSY), .IMM_REQ(IMM_REQ),
   .IMM_DONE(IMM_DONE), .PRG_ADDR(PRG_ADDR), .PRG_RDATA(PRG_RDATA), .OUT_PINS(OUT_PINS),
   .BUS_IN_READY(BUS_IN_READY), .BUS_OUT_VALID(BUS_OUT_VALID), .BUS_OUT_READY(BUS_OUT_READY),
   .BUS_OUT_ADDR(BUS_OUT_ADDR), .BUS_OUT_DATA(BUS_OUT_DATA));

// ---- io_bus_unit_model.sv ----
// bus-unit model: offers numbered words, takes old area words
`timescale 1ns/1ps
module io_bus_unit_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // incoming words
   input wire logic in_ready,
   output logic in_valid,
   output logic [15:0] in_data,
   // outgoing words
   input wire logic out_valid,
   output logic out_ready,
   input wire logic [8:0] out_addr,
   input wire logic [15:0] out_data,
   // stall and log
   input wire logic stall,
   output logic [15:0] sent,
   output logic [15:0] taken,
   output logic [8:0] first_addr,
   output logic [15:0] first_data
);
   assign in_valid = rst_b;
   assign in_data = {4'hc, sent[11:0]};
   // slow reader lets the fifo fill
   assign out_ready = ~stall;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sent <= 16'h0;
         taken <= 16'h0;
         first_addr <= 9'h0;
         first_data <= 16'h0;
      end else begin
         if (in_valid && in_ready) sent <= sent + 16'h1;
         if (out_valid && out_ready) taken <= taken + 16'h1;
         if (out_valid && out_ready && taken == 16'h0) begin
            first_addr <= out_addr;
            first_data <= out_data;
         end
      end
   end
endmodule

// ---- test_io_image_refresh.sv ----
// self-checking bench for the process-image block
`timescale 1ns/1ps
module test_io_image_refresh;
   logic CLK = 1'b0;
   logic RST_B = 1'b0;
   logic MODE_RUN = 1'b1;
   logic FATAL_HALT = 1'b0;
   logic FATAL_USER = 1'b0;
   logic PRG_WE = 1'b0;
   logic SCAN_END = 1'b0;
   logic IMM_REQ = 1'b0;
   logic TOOL_FORCE_REQ = 1'b0;
   logic TOOL_CLEAR = 1'b0;
   logic stall = 1'b0;
   logic [1:0] TOOL_FORCE_OP = 2'h0;
   logic [3:0] TOOL_BIT = 4'h0;
   logic [10:0] PRG_ADDR = 11'h0, IMM_FIRST = 11'h0, IMM_LAST = 11'h0, TOOL_ADDR = 11'h0;
   logic [15:0] PRG_WDATA = 16'h0, PRG_BMASK = 16'h0, BUS_PRESENT = 16'h0;
   logic [319:0] IN_PINS = '0;
   logic [319:0] OUT_PINS;
   logic [15:0] PRG_RDATA, BUS_IN_DATA, BUS_OUT_DATA, sent, taken, first_data;
   logic [8:0] BUS_OUT_ADDR, first_addr;
   logic SCAN_DONE, REFRESH_BUSY, IMM_DONE, BUS_IN_VALID, BUS_IN_READY, BUS_OUT_VALID, BUS_OUT_READY;
   integer failures = 0;
   integer checks = 0;
   always #10 CLK = ~CLK;
   // positions 0,1 input 16 and 20 points, 2,3 output 8 and 16: words 0-2 in, 3-4 out
   io_image_refresh #(.CYC_PER_MS(10), .OFF_DELAY_CYC(30), .FIFO_DEPTH(16)) io_image_refresh_inst (
      .CLK(CLK), .RST_B(RST_B), .MODE_RUN(MODE_RUN), .FATAL_HALT(FATAL_HALT), .FATAL_USER(FATAL_USER),
      .UNIT_KIND(40'ha5), .UNIT_POINTS({112'h0, 7'h10, 7'h08, 7'h14, 7'h10}),
      .UNIT_FILTER_MS({108'h0, 6'h00, 6'h01}), .IN_PINS(IN_PINS), .OUT_PINS(OUT_PINS),
      .PRG_WE(PRG_WE), .PRG_ADDR(PRG_ADDR), .PRG_WDATA(PRG_WDATA), .PRG_BMASK(PRG_BMASK),
      .PRG_RDATA(PRG_RDATA), .SCAN_END(SCAN_END), .SCAN_DONE(SCAN_DONE), .REFRESH_BUSY(REFRESH_BUSY),
      .IMM_REQ(IMM_REQ), .IMM_FIRST(IMM_FIRST), .IMM_LAST(IMM_LAST), .IMM_DONE(IMM_DONE),
      .TOOL_FORCE_REQ(TOOL_FORCE_REQ), .TOOL_FORCE_OP(TOOL_FORCE_OP), .TOOL_ADDR(TOOL_ADDR),
      .TOOL_BIT(TOOL_BIT), .TOOL_CLEAR(TOOL_CLEAR), .BUS_PRESENT(BUS_PRESENT),
      .BUS_IN_VALID(BUS_IN_VALID), .BUS_IN_READY(BUS_IN_READY), .BUS_IN_DATA(BUS_IN_DATA),
      .BUS_OUT_VALID(BUS_OUT_VALID), .BUS_OUT_READY(BUS_OUT_READY), .BUS_OUT_ADDR(BUS_OUT_ADDR),
      .BUS_OUT_DATA(BUS_OUT_DATA));
   io_bus_unit_model io_bus_unit_model_inst (.clk(CLK), .rst_b(RST_B), .in_ready(BUS_IN_READY),
      .in_valid(BUS_IN_VALID), .in_data(BUS_IN_DATA), .out_valid(BUS_OUT_VALID), .out_ready(BUS_OUT_READY),
      .out_addr(BUS_OUT_ADDR), .out_data(BUS_OUT_DATA), .stall(stall), .sent(sent), .taken(taken),
      .first_addr(first_addr), .first_data(first_data));
   function automatic logic [15:0] ow(input int i);
      return OUT_PINS[i*16 +: 16];
   endfunction
   task end_of_test;
      if (failures == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task step;
      @(posedge CLK);
      #2;
   endtask
   task chk(input string n, input logic [15:0] s, input logic [15:0] e);
      checks++;
      if (s !== e) begin
         failures++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   task wr(input logic [10:0] a, input logic [15:0] d, input logic [15:0] m);
      step;
      PRG_WE = 1'b1;
      PRG_ADDR = a;
      PRG_WDATA = d;
      PRG_BMASK = m;
      step;
      PRG_WE = 1'b0;
   endtask
   task rc(input string n, input logic [10:0] a, input logic [15:0] e);
      step;
      PRG_ADDR = a;
      step;
      chk(n, PRG_RDATA, e);
   endtask
   task scan;
      int i;
      step;
      SCAN_END = 1'b1;
      step;
      SCAN_END = 1'b0;
      for (i = 0; i < 3000 && SCAN_DONE !== 1'b1; i++) begin
         if (i == 40 && stall) begin
            chk("ready while full", {15'h0, BUS_IN_READY}, 16'h0);
            stall = 1'b0;
         end
         step;
      end
      chk("scan done", {15'h0, SCAN_DONE}, 16'h1);
   endtask
   task imm(input logic [10:0] f, input logic [10:0] l);
      step;
      IMM_REQ = 1'b1;
      IMM_FIRST = f;
      IMM_LAST = l;
      step;
      IMM_REQ = 1'b0;
      chk("imm done", {15'h0, IMM_DONE}, 16'h1);
   endtask
   task frc(input logic [1:0] op, input logic [10:0] a, input logic [3:0] b);
      step;
      TOOL_FORCE_REQ = 1'b1;
      TOOL_FORCE_OP = op;
      TOOL_ADDR = a;
      TOOL_BIT = b;
      step;
      TOOL_FORCE_REQ = 1'b0;
   endtask
   task hit(input int k);
      step;
      if (k == 0) FATAL_HALT = 1'b1;
      else TOOL_CLEAR = 1'b1;
      step;
      FATAL_HALT = 1'b0;
      TOOL_CLEAR = 1'b0;
   endtask
   task t_outputs;
      wr(11'd3, 16'h00ff, 16'hffff);
      wr(11'd3, 16'h0055, 16'hffff);
      wr(11'd4, 16'h1234, 16'hffff);
      wr(11'd4, 16'hff00, 16'h0f0f);
      wr(11'd10, 16'hbeef, 16'hffff);
      wr(11'd100, 16'hdead, 16'hffff);
      chk("word3 before scan", ow(3), 16'h0);
      scan;
      chk("word3 last write", ow(3), 16'h0055);
      chk("word4 masked", ow(4), 16'h1f30);
      chk("word10 pins", ow(10), 16'h0);
      rc("word10 work", 11'd10, 16'hbeef);
      rc("unmapped", 11'd100, 16'h0);
   endtask
   task t_inputs;
      step;
      IN_PINS[15:0] = 16'ha5a5;
      IN_PINS[31:16] = 16'h3c3c;
      repeat (1010) step;
      rc("input before scan", 11'd0, 16'h0);
      wr(11'd0, 16'hffff, 16'hffff);
      scan;
      rc("input word0", 11'd0, 16'ha5a5);
      rc("input word1", 11'd1, 16'h3c3c);
   endtask
   task t_immediate;
      step;
      IN_PINS[31:16] = 16'h0f0f;
      wr(11'd3, 16'h00aa, 16'hffff);
      wr(11'd4, 16'h4321, 16'hffff);
      repeat (40) step;
      imm(11'd1, 11'd3);
      chk("imm word3", ow(3), 16'h00aa);
      chk("word4 outside range", ow(4), 16'h1f30);
      rc("fall before rise", 11'd1, 16'h0c0c);
      repeat (1000) step;
      imm(11'd1, 11'd1);
      rc("imm word1", 11'd1, 16'h0f0f);
   endtask
   task t_force;
      frc(io_image_pkg::FORCE_SET, 11'd3, 4'h0);
      frc(io_image_pkg::FORCE_RESET, 11'd3, 4'h1);
      frc(io_image_pkg::FORCE_SET, 11'd1500, 4'hf);
      wr(11'd3, 16'h0000, 16'hffff);
      imm(11'd3, 11'd3);
      chk("forced word3", ow(3), 16'h0001);
      rc("forced bus bit", 11'd1500, 16'h8000);
      frc(io_image_pkg::FORCE_RELEASE, 11'd3, 4'h0);
      wr(11'd3, 16'h0000, 16'hffff);
      imm(11'd3, 11'd3);
      chk("one bit released", ow(3), 16'h0);
      frc(io_image_pkg::FORCE_RELEASE_ALL, 11'd3, 4'h0);
      wr(11'd3, 16'h0002, 16'hffff);
      imm(11'd3, 11'd3);
      chk("released word3", ow(3), 16'h0002);
   endtask
   task t_clear;
      wr(11'd10, 16'h5a5a, 16'hffff);
      wr(11'd1525, 16'h7777, 16'hffff);
      FATAL_USER = 1'b1;
      hit(0);
      rc("alarm keeps image", 11'd10, 16'h5a5a);
      rc("alarm keeps bus", 11'd1525, 16'h7777);
      FATAL_USER = 1'b0;
      hit(0);
      rc("fatal clears image", 11'd10, 16'h0);
      rc("fatal clears bus", 11'd1525, 16'h0);
      wr(11'd10, 16'h1111, 16'hffff);
      hit(1);
      rc("tool clear", 11'd10, 16'h0);
      wr(11'd10, 16'h2222, 16'hffff);
      wr(11'd1530, 16'h3333, 16'hffff);
      MODE_RUN = 1'b0;
      rc("mode clears image", 11'd10, 16'h0);
      rc("mode clears bus", 11'd1530, 16'h0);
      MODE_RUN = 1'b1;
   endtask
   task t_bus;
      BUS_PRESENT = 16'h0002;
      wr(11'd1525, 16'h7777, 16'hffff);
      wr(11'd1500, 16'h1111, 16'hffff);
      stall = 1'b1;
      scan;
      chk("words in", sent, 16'd25);
      chk("words out", taken, 16'd25);
      chk("first index", {7'h0, first_addr}, 16'd25);
      chk("first old word", first_data, 16'h7777);
      rc("unit1 word0", 11'd1525, 16'hc000);
      rc("unit1 word24", 11'd1549, 16'hc018);
      rc("absent unit word", 11'd1500, 16'h1111);
   endtask
   // hang guard, far beyond the few thousand cycles needed
   initial begin
      #400000;
      failures++;
      end_of_test;
   end
   initial begin
      repeat (12) @(posedge CLK);
      #2;
      RST_B = 1'b1;
      chk("pins after reset", ow(3), 16'h0);
      t_outputs;
      t_inputs;
      t_immediate;
      t_force;
      t_clear;
      t_bus;
      end_of_test;
   end
endmodule
